//--- hdl/icr_top.sv
// indirect configuration register access: control readback, index, window, clock selection
// Summary of operation
// - control read returns stored bits 4:0
// - control read bits 7:5 read as one
// - control read: select, read low, address 2 or 6 (only bits 1:0 decoded)
// - irq enable gates parallel port interrupt
// - index at offset 3, data via 7
// - index held until rewritten
// - test bit swaps mux interrupt sources
// - bits 6:5 choose uart1 clock
// - bits 4:3 choose uart0 clock
// - index bits 2:0 steer window
// - clock select at index 0, resets zero
// - pin function from strap at reset
// - toggle bit reads 0 under fast port
// - writing 0 leaves pin function
// - writing 1 swaps pin function
// - bit 3 shows pin state under fast
`default_nettype none
module icr_top
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // host bus
  input wire icr_pkg::icr_bus_s bus,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic rdata_oe,
  // strap and mode
  input wire logic irq8_strap,
  input wire logic fast_port_enable,
  // interrupt sources and printer status
  input wire icr_pkg::icr_irq_s irq_raw,
  input wire logic printer_selected_status,
  input wire logic printer_busy_status,
  input wire logic paper_end_status,
  // outputs to the port, mux and clocks
  output logic [4:0] printer_ctrl,
  output icr_pkg::icr_irq_s irq_mux_in,
  output logic [3:0] uart1_clk_sel,
  output logic [3:0] uart0_clk_sel,
  output logic [2:0] coproc_clk_code,
  output logic coprocessor_clock_out_sel
);
  import icr_pkg::*;
  // ==========================================================================
  // decode
  logic sel_rd, sel_wr;
  assign sel_rd = !bus.port_chip_select_b && !bus.ior_b && bus.iow_b;
  assign sel_wr = !bus.port_chip_select_b && bus.ior_b && !bus.iow_b;
  // level strobes: act once per access, on the leading edge
  logic wr_d_r, rd_d_r;
  logic wr_pulse, rd_pulse;
  assign wr_pulse = sel_wr && !wr_d_r;
  assign rd_pulse = sel_rd && !rd_d_r;
  logic ctrl_rd, ctrl_wr, idx_rd, idx_wr, win_rd, win_wr;
  assign ctrl_rd = rd_pulse && (bus.addr[1:0] == ICR_OFS_CTRL[1:0]);
  assign ctrl_wr = wr_pulse && (bus.addr[1:0] == ICR_OFS_CTRL[1:0]);
  assign idx_rd = rd_pulse && (bus.addr == ICR_OFS_INDEX);
  assign idx_wr = wr_pulse && (bus.addr == ICR_OFS_INDEX);
  assign win_rd = rd_pulse && (bus.addr == ICR_OFS_WINDOW);
  assign win_wr = wr_pulse && (bus.addr == ICR_OFS_WINDOW);

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      wr_d_r <= 1'b0;
      rd_d_r <= 1'b0;
    end
    else
    begin
      wr_d_r <= sel_wr;
      rd_d_r <= sel_rd;
    end
  end
  // ==========================================================================
  // registers
  logic [7:0] ctrl_r, index_r, clksel_r, other_r [1:5];
  logic pin_state_r, strap_done_r;
  logic [2:0] win_idx;
  assign win_idx = index_r[2:0];

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      ctrl_r <= ICR_RESET_VAL;
    else if (ctrl_wr)
      ctrl_r <= wdata & ICR_CTRL_WMASK;
  end

  // retained across every other access
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      index_r <= ICR_RESET_VAL;
    else if (idx_wr)
      index_r <= wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      clksel_r <= ICR_RESET_VAL;
    else if (win_wr && win_idx == ICR_IDX_CLKSEL)
      clksel_r <= wdata & ICR_CS_WMASK;
  end

  // other window registers stored plainly; version is read-only, park is dropped
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      for (int i = 1; i <= 5; i++)
        other_r[i] <= ICR_RESET_VAL;
    end
    else if (win_wr && win_idx >= ICR_IDX_CLKDIS && win_idx <= ICR_IDX_MODE)
      other_r[win_idx] <= wdata;
  end

  // strap caught at the first edge after release, then only toggled
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      strap_done_r <= 1'b0;
      pin_state_r <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      strap_done_r <= 1'b1;
      pin_state_r <= !irq8_strap;
    end
    else if (win_wr && win_idx == ICR_IDX_CLKSEL && wdata[ICR_CS_TOGGLE_BIT])
      pin_state_r <= !pin_state_r;
  end
  // ==========================================================================
  // read data
  logic [7:0] win_val, rd_nxt;
  always_comb
  begin
    win_val = ICR_PARK_READ;
    unique case (win_idx)
      ICR_IDX_CLKSEL:
      begin
        win_val = clksel_r;
        if (fast_port_enable)
        begin
          win_val[ICR_CS_TOGGLE_BIT] = 1'b0;
          win_val[ICR_CS_STATE_BIT] = pin_state_r;
        end
      end
      ICR_IDX_VERSION: win_val = ICR_VERSION_VAL;
      ICR_IDX_PARK: win_val = ICR_PARK_READ;
      default: win_val = other_r[win_idx];
    endcase
  end

  always_comb
  begin
    rd_nxt = rdata;
    if (ctrl_rd)
      rd_nxt = ICR_CTRL_ONES | {3'h0, ctrl_r[4:0]};
    else if (idx_rd)
      rd_nxt = index_r;
    else if (win_rd)
      rd_nxt = win_val;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      rdata <= ICR_RESET_VAL;
      rdata_oe <= 1'b0;
    end
    else
    begin
      rdata <= rd_nxt;
      rdata_oe <= sel_rd && (bus.addr[1:0] == ICR_OFS_CTRL[1:0] ||
                  bus.addr == ICR_OFS_INDEX || bus.addr == ICR_OFS_WINDOW);
    end
  end
  // ==========================================================================
  // outputs
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      printer_ctrl <= 5'h00;
      irq_mux_in <= '0;
      coproc_clk_code <= 3'h0;
      coprocessor_clock_out_sel <= 1'b0;
    end
    else
    begin
      printer_ctrl <= ctrl_r[4:0];
      if (index_r[ICR_IDX_TEST_BIT])
        irq_mux_in <= {printer_selected_status, printer_busy_status, paper_end_status};
      else
        irq_mux_in <= {irq_raw.uart1, irq_raw.uart0,
                       irq_raw.par && ctrl_r[ICR_CTRL_IRQ_BIT]};
      coproc_clk_code <= clksel_r[2:0];
      coprocessor_clock_out_sel <= !pin_state_r;
    end
  end

  icr_clock_mux u_uart1_clk
  (
    .mclk(mclk),
    .rst_b(rst_b),
    .choice(index_r[6:5]),
    .sel_onehot(uart1_clk_sel)
  );

  icr_clock_mux u_uart0_clk
  (
    .mclk(mclk),
    .rst_b(rst_b),
    .choice(index_r[4:3]),
    .sel_onehot(uart0_clk_sel)
  );
  // ==========================================================================
  // checks
  ctrl_read_ones_a: assert property (@(posedge mclk) disable iff (!rst_b)
    ctrl_rd |=> rdata[7:5] == 3'h7) else $error("control read high bits not one");
  ctrl_read_back_a: assert property (@(posedge mclk) disable iff (!rst_b)
    ctrl_rd |=> rdata[4:0] == $past(ctrl_r[4:0])) else $error("control readback wrong");
  index_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !idx_wr |=> index_r == $past(index_r)) else $error("index changed without write");
  index_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
    idx_wr |=> index_r == $past(wdata)) else $error("index write lost");
  park_nowrite_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (win_wr && win_idx == ICR_IDX_PARK) |=> clksel_r == $past(clksel_r))
    else $error("parked write changed clock select");
  toggle_zero_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (strap_done_r && !(win_wr && win_idx == ICR_IDX_CLKSEL && wdata[ICR_CS_TOGGLE_BIT]))
    |=> $stable(pin_state_r)) else $error("pin function moved");
  toggle_one_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (strap_done_r && win_wr && win_idx == ICR_IDX_CLKSEL && wdata[ICR_CS_TOGGLE_BIT])
    |=> pin_state_r != $past(pin_state_r)) else $error("toggle did not swap");
  fast_toggle_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (win_rd && win_idx == ICR_IDX_CLKSEL && fast_port_enable) |=> !rdata[ICR_CS_TOGGLE_BIT])
    else $error("toggle bit not zero under fast port");
  irq_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (!index_r[ICR_IDX_TEST_BIT] && !ctrl_r[ICR_CTRL_IRQ_BIT] && $stable(ctrl_r)
     && $stable(index_r)) |=> !irq_mux_in.par) else $error("parallel irq not gated");
endmodule // icr_top
`default_nettype wire

//--- pkg/icr_pkg.sv
// package: offsets, field positions, reset values and carriers for the config register block
`default_nettype none
package icr_pkg;
  // ==========================================================================
  // port offsets on the 3-bit address
  localparam logic [2:0] ICR_OFS_CTRL = 3'h2;
  localparam logic [2:0] ICR_OFS_INDEX = 3'h3;
  localparam logic [2:0] ICR_OFS_WINDOW = 3'h7;
  // ==========================================================================
  // index field values
  localparam logic [2:0] ICR_IDX_CLKSEL = 3'h0;
  localparam logic [2:0] ICR_IDX_CLKDIS = 3'h1;
  localparam logic [2:0] ICR_IDX_SP0INT = 3'h2;
  localparam logic [2:0] ICR_IDX_SP1INT = 3'h3;
  localparam logic [2:0] ICR_IDX_PPINT = 3'h4;
  localparam logic [2:0] ICR_IDX_MODE = 3'h5;
  localparam logic [2:0] ICR_IDX_VERSION = 3'h6;
  localparam logic [2:0] ICR_IDX_PARK = 3'h7;
  // ==========================================================================
  // field positions
  localparam int ICR_CTRL_IRQ_BIT = 4;
  localparam int ICR_IDX_TEST_BIT = 7;
  localparam int ICR_CS_TOGGLE_BIT = 4;
  localparam int ICR_CS_STATE_BIT = 3;
  localparam logic [7:0] ICR_CTRL_ONES = 8'hE0;
  localparam logic [7:0] ICR_CTRL_WMASK = 8'h3F;
  localparam logic [7:0] ICR_CS_WMASK = 8'h1F;
  localparam logic [7:0] ICR_RESET_VAL = 8'h00;
  localparam logic [7:0] ICR_PARK_READ = 8'hFF;
  // arbitrary value, not an identity of any part
  localparam logic [7:0] ICR_VERSION_VAL = 8'h5A;
  // ==========================================================================
  // serial clock choices
  localparam logic [1:0] ICR_UCLK_1M8432 = 2'h0;
  localparam logic [1:0] ICR_UCLK_3M072 = 2'h1;
  localparam logic [1:0] ICR_UCLK_EXT = 2'h2;
  localparam logic [1:0] ICR_UCLK_8M0 = 2'h3;
  // ==========================================================================
  // host bus: strobes, all active low, then the 3-bit address
  typedef struct packed {
    logic port_chip_select_b;
    logic ior_b;
    logic iow_b;
    logic [2:0] addr;
  } icr_bus_s;
  // raw interrupt sources into the mux: uart1, uart0, parallel
  typedef struct packed {
    logic uart1;
    logic uart0;
    logic par;
  } icr_irq_s;
endpackage
`default_nettype wire

//--- hdl/icr_clock_mux.sv
// serial port clock choice: one-hot selects for one uart input clock
`default_nettype none
module icr_clock_mux
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // choice field
  input wire logic [1:0] choice,
  // one-hot select of 1.8432, 3.072, external, 8.0 MHz
  output logic [3:0] sel_onehot
);
  import icr_pkg::*;
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      sel_onehot <= 4'h1;
    else
    begin
      unique case (choice)
        ICR_UCLK_1M8432: sel_onehot <= 4'h1;
        ICR_UCLK_3M072: sel_onehot <= 4'h2;
        ICR_UCLK_EXT: sel_onehot <= 4'h4;
        ICR_UCLK_8M0: sel_onehot <= 4'h8;
      endcase
    end
  end
endmodule // icr_clock_mux
`default_nettype wire

//--- sim/icr_host_model.sv
// host bus master model driving the config register block
`default_nettype none
module icr_host_model
(
  // clock
  input wire logic mclk,
  // bus toward the device
  output icr_pkg::icr_bus_s bus,
  output logic [7:0] wdata,
  // answer
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import icr_pkg::*;
  initial
  begin
    bus = '{1'b1, 1'b1, 1'b1, 3'h0};
    wdata = 8'h00;
  end
  // ==========================================================================
  // one access; strobe goes high for at least a cycle before the next one
  task automatic xfer(input logic wr, input logic [2:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge mclk);
    bus <= '{1'b0, wr, !wr, a};
    wdata <= d;
    @(posedge mclk);
    // released lines show inverted values so stale data cannot pass
    bus <= '{1'b1, 1'b1, 1'b1, ~a};
    wdata <= ~d;
    @(posedge mclk);
    #1 q = rdata;
  endtask
endmodule // icr_host_model
`default_nettype wire

//--- sim/icr_top_tb.sv
// self-checking bench for the config register block
`default_nettype none
module icr_top_tb
  import icr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_b, strap, fast, sel_st, busy_st, pe_st, rdata_oe, pin_sel;
  icr_bus_s bus;
  icr_irq_s irq_raw, irq_mux;
  logic [7:0] wdata, rdata;
  logic [4:0] pctl;
  logic [3:0] u1, u0;
  logic [2:0] cpc;
  int n_errors = 0;
  int check_count = 0;
  icr_host_model icr_host_model_inst (.mclk(mclk), .bus(bus), .wdata(wdata), .rdata(rdata));
  icr_top icr_top_inst (.mclk(mclk), .rst_b(rst_b), .bus(bus), .wdata(wdata), .rdata(rdata),
    .rdata_oe(rdata_oe), .irq8_strap(strap), .fast_port_enable(fast), .irq_raw(irq_raw),
    .printer_selected_status(sel_st), .printer_busy_status(busy_st),
    .paper_end_status(pe_st), .printer_ctrl(pctl), .irq_mux_in(irq_mux),
    .uart1_clk_sel(u1), .uart0_clk_sel(u0), .coproc_clk_code(cpc),
    .coprocessor_clock_out_sel(pin_sel));
  // ==========================================================================
  // helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    icr_host_model_inst.xfer(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic oe;
    logic mapped;
    mapped = (a[1:0] == ICR_OFS_CTRL[1:0]) || (a == ICR_OFS_INDEX) || (a == ICR_OFS_WINDOW);
    // output enable stands only the cycle after the strobe edge, so look there
    fork
      icr_host_model_inst.xfer(1'b0, a, 8'h00, q);
      begin
        repeat (2) @(posedge mclk);
        #1 oe = rdata_oe;
      end
    join
    check(q, exp);
    check({7'h00, oe}, {7'h00, mapped});
  endtask
  task automatic settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic do_reset(input logic s);
    @(posedge mclk);
    rst_b <= 1'b0;
    strap <= s;
    fast <= 1'b0;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    settle();
  endtask
  task automatic final_report;
    if (n_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset(input logic s);
    rd_chk(ICR_OFS_INDEX, ICR_RESET_VAL);
    rd_chk(ICR_OFS_CTRL, ICR_CTRL_ONES);
    rd_chk(ICR_OFS_WINDOW, ICR_RESET_VAL);
    check({7'h00, pin_sel}, {7'h00, s});
    check({3'h0, pctl}, 8'h00);
    check({u1, u0}, 8'h11);
  endtask
  task automatic t_ctrl;
    wr(ICR_OFS_CTRL, 8'hFF);
    rd_chk(3'h6, 8'hFF);
    wr(3'h6, 8'h0A);
    rd_chk(ICR_OFS_CTRL, 8'hEA);
    rd_chk(3'h4, 8'hEA);
    check({3'h0, pctl}, 8'h0A);
  endtask
  task automatic t_irq;
    @(posedge mclk);
    irq_raw <= 3'b111;
    settle();
    check({5'h00, irq_mux}, 8'h06);
    wr(ICR_OFS_CTRL, 8'h10);
    settle();
    check({5'h00, irq_mux}, 8'h07);
    @(posedge mclk);
    irq_raw <= 3'b000;
    sel_st <= 1'b1;
    busy_st <= 1'b1;
    pe_st <= 1'b0;
    wr(ICR_OFS_INDEX, 8'h87);
    settle();
    check({5'h00, irq_mux}, 8'h06);
    @(posedge mclk);
    busy_st <= 1'b0;
    pe_st <= 1'b1;
    settle();
    check({5'h00, irq_mux}, 8'h05);
  endtask
  task automatic t_index;
    logic [7:0] idx;
    for (int k = 0; k < 4; k++)
    begin
      idx = {1'b0, k[1:0], 2'(3 - k), ICR_IDX_PARK};
      wr(ICR_OFS_INDEX, idx);
      wr(ICR_OFS_CTRL, 8'h00);
      rd_chk(ICR_OFS_INDEX, idx);
      check({4'h0, u1}, 8'h01 << k);
      check({4'h0, u0}, 8'h01 << (3 - k));
    end
  endtask
  task automatic t_window;
    for (int i = 1; i < 7; i++)
    begin
      wr(ICR_OFS_INDEX, 8'(i));
      wr(ICR_OFS_WINDOW, 8'(8'h30 + i));
    end
    wr(ICR_OFS_INDEX, 8'h00);
    wr(ICR_OFS_WINDOW, 8'h05);
    settle();
    check({5'h00, cpc}, 8'h05);
    for (int i = 0; i < 7; i++)
    begin
      wr(ICR_OFS_INDEX, 8'(i));
      rd_chk(ICR_OFS_WINDOW, i == 0 ? 8'h05 : i == 6 ? ICR_VERSION_VAL : 8'(8'h30 + i));
    end
    wr(ICR_OFS_INDEX, {5'h00, ICR_IDX_PARK});
    wr(ICR_OFS_WINDOW, 8'h1F);
    rd_chk(ICR_OFS_WINDOW, ICR_PARK_READ);
    wr(ICR_OFS_INDEX, 8'h00);
    rd_chk(ICR_OFS_WINDOW, 8'h05);
  endtask
  task automatic t_pin;
    wr(ICR_OFS_WINDOW, 8'h15);
    settle();
    check({7'h00, pin_sel}, 8'h00);
    wr(ICR_OFS_WINDOW, 8'h05);
    settle();
    check({7'h00, pin_sel}, 8'h00);
    wr(ICR_OFS_WINDOW, 8'h1D);
    settle();
    check({7'h00, pin_sel}, 8'h01);
    rd_chk(ICR_OFS_WINDOW, 8'h1D);
    @(posedge mclk);
    fast <= 1'b1;
    rd_chk(ICR_OFS_WINDOW, 8'h05);
    wr(ICR_OFS_WINDOW, 8'h10);
    rd_chk(ICR_OFS_WINDOW, 8'h08);
  endtask
  // ==========================================================================
  // clock, stimulus and watchdog
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial
  begin
    rst_b = 1'b0;
    strap = 1'b1;
    fast = 1'b0;
    irq_raw = 3'b000;
    sel_st = 1'b0;
    busy_st = 1'b0;
    pe_st = 1'b0;
    do_reset(1'b1);
    t_reset(1'b1);
    t_ctrl();
    t_irq();
    t_index();
    t_window();
    t_pin();
    // a second reset mid-run with the strap low
    do_reset(1'b0);
    t_reset(1'b0);
    final_report();
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    final_report();
  end
endmodule // icr_top_tb
`default_nettype wire
